// >>> shared/dicp_pkg.sv
package dicp_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    // 18-bit conversion period: 3 samples per second
    localparam longint unsigned CONV_PERIOD_18_NS = 64'd333333333;
    localparam int unsigned CONV_CYC_18_DEF =
        int'(CONV_PERIOD_18_NS / CLK_PERIOD_NS);
    // host poll window of 320 ms, shorter than the 333 ms 18-bit conversion period
    localparam longint unsigned POLL_WINDOW_NS = 64'd320000000;
    localparam int unsigned POLL_WINDOW_CYC_DEF =
        int'(POLL_WINDOW_NS / CLK_PERIOD_NS);
    localparam logic [2:0] POLL_MAX = 3'h3;

    // ----------------------------------------------------------------
    // register pointers
    // ----------------------------------------------------------------
    localparam logic [7:0] PTR_ALERT_CFG = 8'h08;
    localparam logic [7:0] PTR_IDENT = 8'h20;
    localparam logic [7:0] PTR_PACE_CFG = 8'h30;
    localparam logic [7:0] PTR_PACE_STAT = 8'h31;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ACFG_INT_CLR = 7;
    localparam int ACFG_POL = 2;
    localparam int ACFG_MODE = 1;
    localparam int ACFG_EN = 0;
    localparam logic [4:0] ACFG_WMASK = 5'h1F;
    localparam logic [4:0] ACFG_RST = 5'h00;
    localparam int PCFG_RUN = 2;
    localparam logic [2:0] PCFG_RST = 3'h0;
    localparam int PSTAT_OVER = 3;

    // ----------------------------------------------------------------
    // resolution codes, period dividers, compute share in percent
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DICP_RES_18 = 2'h0,
        DICP_RES_16 = 2'h1,
        DICP_RES_14 = 2'h2,
        DICP_RES_12 = 2'h3
    } dicp_res_t;
    localparam int unsigned DIV_16 = 5;
    localparam int unsigned DIV_14 = 20;
    localparam int unsigned DIV_12 = 80;
    localparam int unsigned PCT_18 = 5;
    localparam int unsigned PCT_16 = 20;
    localparam int unsigned PCT_14 = 80;
    localparam int unsigned PCT_12 = 100;

    typedef enum logic [1:0] {
        DICP_IDLE = 2'h0,
        DICP_DIGIT = 2'h1,
        DICP_CALC = 2'h3
    } dicp_state_t;

    typedef struct packed {
        logic [7:0] ptr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } dicp_reg_req_t;

endpackage

// >>> rtl/dicp_top.sv
`timescale 1ns/1ps
module dicp_top
    import dicp_pkg::*;
#(
    parameter int unsigned CONV_CYC_18 = CONV_CYC_18_DEF,
    parameter int unsigned POLL_WINDOW_CYC = POLL_WINDOW_CYC_DEF,
    parameter bit WIRE_FAULT_VARIANT = 1'b0,
    // identity values are arbitrary
    parameter logic [7:0] VARIANT_PLAIN = 8'hA5,
    parameter logic [7:0] VARIANT_WIRE_FAULT = 8'hA6,
    parameter logic [3:0] REV_MAJOR = 4'h2,
    parameter logic [3:0] REV_MINOR = 4'h3
)(
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // register access from the serial interface logic
    input wire dicp_reg_req_t REG_REQ_I,
    output logic [15:0] REG_RDATA_O,
    // alert comparator result and alert line
    input wire logic ALERT_TRIP_I,
    output logic ALERT_O,
    // conversion pacing
    output logic SAMPLE_READY_O,
    output logic COMPUTE_BUSY_O,
    output logic POLL_OVER_O
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [23:0] period_of(input logic [1:0] res);
        int unsigned p;
        case (res)
            DICP_RES_16: p = CONV_CYC_18 / DIV_16;
            DICP_RES_14: p = CONV_CYC_18 / DIV_14;
            DICP_RES_12: p = CONV_CYC_18 / DIV_12;
            default: p = CONV_CYC_18;
        endcase
        if (p < 2)
            p = 2;
        return p[23:0];
    endfunction

    function automatic logic [23:0] calc_of(input logic [1:0] res);
        int unsigned p;
        int unsigned c;
        p = 32'(period_of(res));
        case (res)
            DICP_RES_16: c = p * PCT_16 / 100;
            DICP_RES_14: c = p * PCT_14 / 100;
            DICP_RES_12: c = p * PCT_12 / 100 - 1;
            default: c = p * PCT_18 / 100;
        endcase
        if (c < 1)
            c = 1;
        return c[23:0];
    endfunction

    localparam logic [15:0] IDENT_WORD = {
        (WIRE_FAULT_VARIANT ? VARIANT_WIRE_FAULT : VARIANT_PLAIN),
        REV_MAJOR, REV_MINOR};

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rdata;
        logic [4:0] acfg;
        logic irq;
        logic trip_d;
        logic alert;
        logic [2:0] pcfg;
        dicp_state_t st;
        logic [23:0] cnt;
        logic ready;
        logic busy;
        logic [22:0] win;
        logic [2:0] polls;
        logic over;
    } dicp_st_t;

    dicp_st_t s_r;
    dicp_st_t s_nxt;
    logic wr_acfg;
    logic wr_pcfg;
    logic wr_pstat;
    logic act;

    assign wr_acfg = REG_REQ_I.wr && REG_REQ_I.ptr == PTR_ALERT_CFG;
    assign wr_pcfg = REG_REQ_I.wr && REG_REQ_I.ptr == PTR_PACE_CFG;
    assign wr_pstat = REG_REQ_I.wr && REG_REQ_I.ptr == PTR_PACE_STAT;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ready = 1'b0;
        // ------------------------------------------------------------
        // register writes; the identification word has no write path
        // ------------------------------------------------------------
        if (wr_acfg)
            s_nxt.acfg = REG_REQ_I.wdata[4:0] & ACFG_WMASK;
        if (wr_pcfg)
            s_nxt.pcfg = REG_REQ_I.wdata[2:0];
        // ------------------------------------------------------------
        // alert: interrupt latch, set wins over clear
        // ------------------------------------------------------------
        s_nxt.trip_d = ALERT_TRIP_I;
        if (wr_acfg && REG_REQ_I.wdata[ACFG_INT_CLR])
            s_nxt.irq = 1'b0;
        if (ALERT_TRIP_I && !s_r.trip_d && s_r.acfg[ACFG_EN])
            s_nxt.irq = 1'b1;
        act = s_r.acfg[ACFG_MODE] ? s_r.irq : ALERT_TRIP_I;
        act = act && s_r.acfg[ACFG_EN];
        s_nxt.alert = s_r.acfg[ACFG_POL] ? act : !act;
        // ------------------------------------------------------------
        // conversion pacing: digitize then compute
        // ------------------------------------------------------------
        case (s_r.st)
            DICP_IDLE:
            begin
                if (s_r.pcfg[PCFG_RUN])
                begin
                    s_nxt.st = DICP_DIGIT;
                    s_nxt.cnt = period_of(s_r.pcfg[1:0])
                        - calc_of(s_r.pcfg[1:0]) - 24'h1;
                end
            end
            DICP_DIGIT:
            begin
                if (s_r.cnt == 24'h0)
                begin
                    s_nxt.st = DICP_CALC;
                    s_nxt.busy = 1'b1;
                    s_nxt.cnt = calc_of(s_r.pcfg[1:0]) - 24'h1;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 24'h1;
                end
            end
            DICP_CALC:
            begin
                if (s_r.cnt == 24'h0)
                begin
                    s_nxt.ready = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.st = s_r.pcfg[PCFG_RUN] ? DICP_DIGIT : DICP_IDLE;
                    s_nxt.cnt = period_of(s_r.pcfg[1:0])
                        - calc_of(s_r.pcfg[1:0]) - 24'h1;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 24'h1;
                end
            end
            default:
            begin
                s_nxt.st = DICP_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase
        // ------------------------------------------------------------
        // poll monitor over one 320 ms window
        // ------------------------------------------------------------
        if (wr_pstat && REG_REQ_I.wdata[PSTAT_OVER])
            s_nxt.over = 1'b0;
        // a read in the last cycle belongs to the window that ends
        if (s_r.win == 23'(POLL_WINDOW_CYC - 1))
        begin
            s_nxt.win = 23'h0;
            s_nxt.polls = 3'h0;
        end
        else
        begin
            s_nxt.win = s_r.win + 23'h1;
            if (REG_REQ_I.rd && s_r.polls != 3'h7)
            begin
                s_nxt.polls = s_r.polls + 3'h1;
            end
        end
        if (REG_REQ_I.rd && s_r.polls >= POLL_MAX)
            s_nxt.over = 1'b1;
        // ------------------------------------------------------------
        // read data, one cycle after the strobe
        // ------------------------------------------------------------
        if (REG_REQ_I.rd)
        begin
            case (REG_REQ_I.ptr)
                PTR_IDENT: s_nxt.rdata = IDENT_WORD;
                PTR_ALERT_CFG: s_nxt.rdata = {11'h0, s_r.acfg};
                PTR_PACE_CFG: s_nxt.rdata = {13'h0, s_r.pcfg};
                PTR_PACE_STAT:
                    s_nxt.rdata = {12'h0, s_r.over, s_r.busy, s_r.st};
                default: s_nxt.rdata = 16'h0;
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            s_r <= '{rdata: 16'h0, acfg: ACFG_RST, irq: 1'b0,
                trip_d: 1'b0, alert: 1'b1, pcfg: PCFG_RST,
                st: DICP_IDLE, cnt: 24'h0, ready: 1'b0, busy: 1'b0,
                win: 23'h0, polls: 3'h0, over: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign REG_RDATA_O = s_r.rdata;
    assign ALERT_O = s_r.alert;
    assign SAMPLE_READY_O = s_r.ready;
    assign COMPUTE_BUSY_O = s_r.busy;
    assign POLL_OVER_O = s_r.over;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_ident_read;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        REG_REQ_I.rd && REG_REQ_I.ptr == PTR_IDENT
        |=> REG_RDATA_O == IDENT_WORD;
    endproperty
    a_ident_read: assert property (p_ident_read)
        else $error("identification word read back wrong");

    property p_ident_variant;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        REG_REQ_I.rd && REG_REQ_I.ptr == PTR_IDENT
        |=> REG_RDATA_O[15:8] == (WIRE_FAULT_VARIANT ?
            VARIANT_WIRE_FAULT : VARIANT_PLAIN);
    endproperty
    a_ident_variant: assert property (p_ident_variant)
        else $error("variant code wrong");

    property p_ident_rev;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        REG_REQ_I.rd && REG_REQ_I.ptr == PTR_IDENT
        |=> REG_RDATA_O[7:4] == REV_MAJOR && REG_RDATA_O[3:0] == REV_MINOR;
    endproperty
    a_ident_rev: assert property (p_ident_rev)
        else $error("revision nibbles wrong");

    property p_calc_after_digit;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        s_r.st == DICP_DIGIT && s_r.cnt == 24'h0
        |=> s_r.st == DICP_CALC && COMPUTE_BUSY_O;
    endproperty
    a_calc_after_digit: assert property (p_calc_after_digit)
        else $error("computation phase did not follow digitization");

    property p_ready_ends_calc;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        $rose(SAMPLE_READY_O) |-> $past(s_r.st) == DICP_CALC
            && !COMPUTE_BUSY_O;
    endproperty
    a_ready_ends_calc: assert property (p_ready_ends_calc)
        else $error("result ready without computation phase");

    property p_period_load;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        s_r.st == DICP_CALC && s_r.cnt == 24'h0 && s_r.pcfg[PCFG_RUN]
        |=> s_r.cnt == period_of($past(s_r.pcfg[1:0]))
            - calc_of($past(s_r.pcfg[1:0])) - 24'h1;
    endproperty
    a_period_load: assert property (p_period_load)
        else $error("conversion period reload wrong");

    property p_int_clear;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        wr_acfg && REG_REQ_I.wdata[ACFG_INT_CLR]
            && !(ALERT_TRIP_I && !s_r.trip_d)
        |=> !s_r.irq ##1 ALERT_O != s_r.acfg[ACFG_POL]
            || !s_r.acfg[ACFG_MODE];
    endproperty
    a_int_clear: assert property (p_int_clear)
        else $error("interrupt clear did not deassert alert");

    property p_clr_reads_zero;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        REG_REQ_I.rd && REG_REQ_I.ptr == PTR_ALERT_CFG
        |=> REG_RDATA_O[ACFG_INT_CLR] == 1'b0;
    endproperty
    a_clr_reads_zero: assert property (p_clr_reads_zero)
        else $error("interrupt clear bit did not read zero");

endmodule // dicp_top

// >>> verif/dicp_host.sv
`timescale 1ns/1ps
module dicp_host
    import dicp_pkg::*;
#(
    parameter int unsigned WINDOW = 50
)(
    // clock
    input wire logic clk_i,
    // register port
    input wire logic [15:0] rdata_i,
    output dicp_reg_req_t req_o
);
    // ----------------------------------------------------------------
    // host transfers
    // ----------------------------------------------------------------
    bit pace = 1'b0;
    initial req_o = '0;

    task automatic xfer(input logic [7:0] p, input logic w,
        input logic [15:0] d, output logic [15:0] q);
        // spaced reads keep any poll window to three reads
        if (pace && !w)
            repeat (WINDOW / 3 + 1) @(posedge clk_i);
        @(posedge clk_i);
        req_o <= '{ptr: p, wr: w, rd: !w, wdata: d};
        @(posedge clk_i);
        // released lines do not keep the last value
        req_o <= '{ptr: ~p, wr: 1'b0, rd: 1'b0, wdata: ~d};
        #1;
        q = rdata_i;
    endtask
endmodule // dicp_host

// >>> verif/dicp_top_bench.sv
`timescale 1ns/1ps
module dicp_top_bench
    import dicp_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int CONV = 800;
    logic CLK_I;
    logic SYS_RST_I = 1'b1;
    logic ALERT_TRIP_I = 1'b0;
    dicp_reg_req_t req;
    logic [15:0] rdata;
    logic [15:0] q;
    logic alert, ready, busy, over;
    int failures = 0;
    int checked = 0;
    int t, c, p;
    int divs[4] = '{1, DIV_16, DIV_14, DIV_12};
    int pcts[4] = '{PCT_18, PCT_16, PCT_14, PCT_12};

    // minor revision left at its default of 3
    dicp_top #(.CONV_CYC_18(CONV), .POLL_WINDOW_CYC(50),
        .WIRE_FAULT_VARIANT(1'b1), .VARIANT_WIRE_FAULT(8'h6B),
        .REV_MAJOR(4'h1)) uut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
        .REG_REQ_I(req), .REG_RDATA_O(rdata),
        .ALERT_TRIP_I(ALERT_TRIP_I), .ALERT_O(alert),
        .SAMPLE_READY_O(ready), .COMPUTE_BUSY_O(busy),
        .POLL_OVER_O(over));

    dicp_host host (.clk_i(CLK_I), .rdata_i(rdata),
        .req_o(req));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask

    task automatic rd(logic [7:0] a);
        host.xfer(a, 1'b0, 16'h0000, q);
    endtask

    task automatic wr(logic [7:0] a, logic [15:0] d);
        host.xfer(a, 1'b1, d, q);
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask

    // cycles up to the next ready pulse, and busy cycles among them
    task automatic measure(output int n, output int b);
        n = 0;
        b = 0;
        do
        begin
            tick(1);
            n++;
            if (busy === 1'b1)
                b++;
        end while (ready !== 1'b1 && n < 4000);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------------------------------
    initial
    begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end

    initial
    begin
        repeat (50000) @(posedge CLK_I);
        failures++;
        results();
    end

    initial
    begin
        repeat (2) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        #1;
        chk("rdata", 16'h0000, rdata);
        chk("alert", 16'h0001, {15'h0, alert});
        chk("flags", 16'h0000, {13'h0, ready, busy, over});
        $display("test reset done");

        rd(PTR_IDENT);
        chk("ident", 16'h6B13, q);
        wr(PTR_IDENT, 16'hFFFF);
        rd(PTR_IDENT);
        chk("ident after write", 16'h6B13, q);
        rd(8'h55);
        chk("unmapped", 16'h0000, q);
        $display("test ident done");

        wr(PTR_ALERT_CFG, 16'h0007);
        @(posedge CLK_I) ALERT_TRIP_I <= 1'b1;
        @(posedge CLK_I) ALERT_TRIP_I <= 1'b0;
        tick(3);
        chk("latched alert", 16'h0001, {15'h0, alert});
        wr(PTR_ALERT_CFG, 16'h0087);
        tick(2);
        chk("cleared alert", 16'h0000, {15'h0, alert});
        rd(PTR_ALERT_CFG);
        chk("alert cfg", 16'h0007, q);
        wr(PTR_ALERT_CFG, 16'h0005);
        @(posedge CLK_I) ALERT_TRIP_I <= 1'b1;
        tick(3);
        chk("comparator on", 16'h0001, {15'h0, alert});
        @(posedge CLK_I) ALERT_TRIP_I <= 1'b0;
        tick(3);
        chk("comparator off", 16'h0000, {15'h0, alert});
        $display("test alert done");

        for (int r = 0; r < 4; r++)
        begin
            wr(PTR_PACE_CFG, 16'h0004 | 16'(r));
            measure(t, c);
            measure(t, c);
            measure(t, c);
            p = CONV / divs[r];
            chk("period", 16'(p), 16'(t));
            chk("compute", 16'((r == 3) ? p - 1 : p * pcts[r] / 100),
                16'(c));
        end
        rd(PTR_PACE_CFG);
        chk("pace cfg", 16'h0007, q);
        $display("test pacing done");

        wr(PTR_PACE_STAT, 16'h0008);
        tick(1);
        chk("over cleared", 16'h0000, {15'h0, over});
        host.pace = 1'b1;
        repeat (4) rd(PTR_IDENT);
        tick(1);
        chk("paced polls", 16'h0000, {15'h0, over});
        host.pace = 1'b0;
        // seven reads put four into one window wherever it wraps
        repeat (7) rd(PTR_IDENT);
        tick(1);
        chk("over set", 16'h0001, {15'h0, over});
        rd(PTR_PACE_STAT);
        chk("over bit", 16'h0001, {15'h0, q[PSTAT_OVER]});
        wr(PTR_PACE_STAT, 16'h0008);
        tick(1);
        chk("over clear", 16'h0000, {15'h0, over});
        $display("test polling done");
        results();
    end
endmodule // dicp_top_bench
